// ### pkg/ivs_pkg.sv
// constants for the interrupt vector and special-function register block
package ivs_pkg;
    // ==========================================================
    // register offsets
    localparam logic [3:0] IVS_OFF_EN1 = 4'h0;
    localparam logic [3:0] IVS_OFF_EN2 = 4'h1;
    localparam logic [3:0] IVS_OFF_FLG1 = 4'h2;
    localparam logic [3:0] IVS_OFF_FLG2 = 4'h3;
    // ==========================================================
    // bit positions
    localparam int IVS_B_WDOG = 0;
    localparam int IVS_B_OSC = 1;
    localparam int IVS_B_POR = 2;
    localparam int IVS_B_EXT = 3;
    localparam int IVS_B_NMI = 4;
    localparam int IVS_B_FLV = 5;
    localparam logic [7:0] IVS_EN1_MASK = 8'h33;
    localparam logic [7:0] IVS_FLG1_MASK = 8'h1f;
    localparam logic [7:0] IVS_EN1_RST = 8'h00;
    // ==========================================================
    // vector words
    localparam logic [15:0] IVS_VEC_TOP = 16'hffff;
    localparam logic [15:0] IVS_VEC_BOT = 16'hffc0;
    localparam logic [15:0] IVS_VEC_RESET = 16'hfffe;
    localparam logic [15:0] IVS_VEC_NMI = 16'hfffc;
    localparam logic [15:0] IVS_VEC_COMP = 16'hfff6;
    localparam logic [15:0] IVS_VEC_WDOG = 16'hfff4;
    localparam logic [15:0] IVS_VEC_CC0 = 16'hfff2;
    localparam logic [15:0] IVS_VEC_CC1 = 16'hfff0;
    localparam logic [15:0] IVS_VEC_P2 = 16'hffe6;
    localparam logic [15:0] IVS_VEC_P1 = 16'hffe4;
    localparam logic [15:0] IVS_VEC_UNUSED_TOP = 16'hffde;
    localparam logic [15:0] IVS_ERASED = 16'hffff;
    localparam logic [15:0] IVS_PERIPH_TOP = 16'h01ff;
    // ==========================================================
    // priorities
    localparam logic [4:0] IVS_PRI_RESET = 5'h1f;
    localparam logic [4:0] IVS_PRI_NMI = 5'h1e;
    localparam logic [4:0] IVS_PRI_COMP = 5'h1b;
    localparam logic [4:0] IVS_PRI_WDOG = 5'h1a;
    localparam logic [4:0] IVS_PRI_CC0 = 5'h19;
    localparam logic [4:0] IVS_PRI_CC1 = 5'h18;
    localparam logic [4:0] IVS_PRI_P2 = 5'h13;
    localparam logic [4:0] IVS_PRI_P1 = 5'h12;
endpackage

// ### src/ivs_core.sv
// vector selection, priority and special-function registers
`timescale 1ns/10ps
// Overview of operation
// - vectors and start address live in words ffff down to ffc0
// - erased reset vector sends the cpu straight into deepest sleep
// - all reset causes use vector fffe at priority 31
// - nmi pin, oscillator fault, flash violation share fffc, priority 30
// - those sources obey own enable only, not the global enable
// - comparator uses fff6 priority 27, watchdog interval fff4 priority 26
// - channel 0 uses fff2; channel 1 and overflow share fff0
// - port 2 bits 6,7 use ffe6; port 1 flags use ffe4
// - words ffde to ffc0 are never fetched as vectors
// - fetch from 0 to 01ff or outside code_bot_in to code_top_in causes reset
// - unassigned register bits are not implemented
// - enable register bits 0,1,4,5 read/write, cleared by power-up clear
// - watchdog enable acts only in interval timer mode
// - flag register holds watchdog, osc, power-on, ext reset, nmi bits
// - watchdog flag set on overflow or key fault, cleared by power-on or pin reset
// - external reset flag set by pin reset, cleared on power-up
// - power-on flag set on supply power-up
// - nmi flag set by pin; osc fault flag set by fault and by clear
// - deepest sleep stops cpu, all clocks, generator and crystal
module ivs_core
    import ivs_pkg::*;
#(
    parameter bit HAS_COMP = 1'b1
)(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic por_in,
    input wire logic puc_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic gie_in,
    input wire logic wdog_interval_mode_in,
    input wire logic wdog_expire_in,
    input wire logic flash_key_viol_flag_in,
    input wire logic pin_reset_in,
    input wire logic pin_nmi_in,
    input wire logic osc_fault_in,
    input wire logic flash_viol_flag_in,
    input wire logic comparator_flag_in,
    input wire logic cc_chan0_flag_in,
    input wire logic cc_chan1_flag_in,
    input wire logic timer_overflow_flag_in,
    input wire logic [1:0] port2_pin_flags_in,
    input wire logic [7:0] port1_pin_flags_in,
    input wire logic fetch_in,
    input wire logic [15:0] fetch_addr_in,
    input wire logic [15:0] code_top_in,
    input wire logic [15:0] code_bot_in,
    input wire logic [15:0] reset_vec_word_in,
    input wire logic boot_check_in,
    output logic int_req_out,
    output logic [15:0] vec_addr_out,
    output logic [4:0] vec_pri_out,
    output logic fetch_reset_out,
    output logic deepest_sleep_mode_out,
    output logic clocks_on_out
);
    // ==========================================================
    // pin synchronisers
    logic pr_s1_q, pn_s1_q, of_s1_q;
    logic [1:0] pr_s2_q, pn_s2_q, of_s2_q;
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            pr_s1_q <= 1'b0;
            pr_s2_q <= 2'h0;
            pn_s1_q <= 1'b0;
            pn_s2_q <= 2'h0;
            of_s1_q <= 1'b0;
            of_s2_q <= 2'h0;
        end
        else
        begin
            pr_s1_q <= pin_reset_in;
            pr_s2_q <= {pr_s2_q[0], pr_s1_q};
            pn_s1_q <= pin_nmi_in;
            pn_s2_q <= {pn_s2_q[0], pn_s1_q};
            of_s1_q <= osc_fault_in;
            of_s2_q <= {of_s2_q[0], of_s1_q};
        end
    end
    logic pin_reset_rise, pin_nmi_rise, osc_fault_lvl;
    assign pin_reset_rise = pr_s2_q[0] & ~pr_s2_q[1];
    assign pin_nmi_rise = pn_s2_q[0] & ~pn_s2_q[1];
    assign osc_fault_lvl = of_s2_q[0];

    // ==========================================================
    // register access
    logic wr_en1, wr_flg1;
    assign wr_en1 = wr_in && (addr_in == IVS_OFF_EN1);
    assign wr_flg1 = wr_in && (addr_in == IVS_OFF_FLG1);

    logic [7:0] en1_q;
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            en1_q <= IVS_EN1_RST;
        else if (puc_in)
            en1_q <= IVS_EN1_RST;
        else if (wr_en1)
            en1_q <= wdata_in & IVS_EN1_MASK;
    end

    // flag register bits; set beats software clear
    logic wdog_f_q, osc_f_q, por_f_q, ext_f_q, nmi_f_q;
    logic wdog_set, wdog_int_set;
    assign wdog_set = (wdog_expire_in & ~wdog_interval_mode_in)
                    | flash_key_viol_flag_in;
    assign wdog_int_set = wdog_expire_in & wdog_interval_mode_in;

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            wdog_f_q <= 1'b0;
        else if (wdog_set | wdog_int_set)
            wdog_f_q <= 1'b1;
        else if (por_in | pin_reset_rise)
            wdog_f_q <= 1'b0;
        else if (wr_flg1)
            wdog_f_q <= wdata_in[IVS_B_WDOG];
    end

    // osc fault flag, also set by power-up clear
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            osc_f_q <= 1'b1;
        else if (osc_fault_lvl | puc_in)
            osc_f_q <= 1'b1;
        else if (wr_flg1)
            osc_f_q <= wdata_in[IVS_B_OSC];
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            por_f_q <= 1'b1;
        else if (por_in)
            por_f_q <= 1'b1;
        else if (wr_flg1)
            por_f_q <= wdata_in[IVS_B_POR];
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            ext_f_q <= 1'b0;
        else if (pin_reset_rise)
            ext_f_q <= 1'b1;
        else if (por_in)
            ext_f_q <= 1'b0;
        else if (wr_flg1)
            ext_f_q <= wdata_in[IVS_B_EXT];
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            nmi_f_q <= 1'b0;
        else if (pin_nmi_rise)
            nmi_f_q <= 1'b1;
        else if (por_in)
            nmi_f_q <= 1'b0;
        else if (wr_flg1)
            nmi_f_q <= wdata_in[IVS_B_NMI];
    end

    logic [7:0] flg1;
    assign flg1 = {3'h0, nmi_f_q, ext_f_q, por_f_q, osc_f_q, wdog_f_q};

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            rdata_out <= 8'h00;
        else if (rd_in && addr_in == IVS_OFF_EN1)
            rdata_out <= en1_q;
        else if (rd_in && addr_in == IVS_OFF_FLG1)
            rdata_out <= flg1;
        else
            rdata_out <= 8'h00;
    end

    // ==========================================================
    // request qualification
    logic rq_nmi, rq_comp, rq_wdog, rq_cc0, rq_cc1, rq_p2, rq_p1;
    // own enables only, no global gate
    assign rq_nmi = (nmi_f_q & en1_q[IVS_B_NMI])
                  | (osc_f_q & en1_q[IVS_B_OSC])
                  | (flash_viol_flag_in & en1_q[IVS_B_FLV]);
    assign rq_comp = gie_in & HAS_COMP & comparator_flag_in;
    // watchdog enable in interval mode only
    assign rq_wdog = gie_in & wdog_f_q & en1_q[IVS_B_WDOG]
                   & wdog_interval_mode_in;
    assign rq_cc0 = gie_in & cc_chan0_flag_in;
    assign rq_cc1 = gie_in & (cc_chan1_flag_in | timer_overflow_flag_in);
    assign rq_p2 = gie_in & (|port2_pin_flags_in);
    assign rq_p1 = gie_in & (|port1_pin_flags_in);

    // ==========================================================
    // fixed priority pick
    // every vector is a word in the top range
    logic [15:0] vec_d;
    logic [4:0] pri_d;
    logic req_d;
    always_comb
    begin
        req_d = 1'b1;
        vec_d = IVS_VEC_RESET;
        pri_d = IVS_PRI_RESET;
        if (rq_nmi)
        begin
            vec_d = IVS_VEC_NMI;
            pri_d = IVS_PRI_NMI;
        end
        else if (rq_comp)
        begin
            vec_d = IVS_VEC_COMP;
            pri_d = IVS_PRI_COMP;
        end
        else if (rq_wdog)
        begin
            vec_d = IVS_VEC_WDOG;
            pri_d = IVS_PRI_WDOG;
        end
        else if (rq_cc0)
        begin
            vec_d = IVS_VEC_CC0;
            pri_d = IVS_PRI_CC0;
        end
        else if (rq_cc1)
        begin
            vec_d = IVS_VEC_CC1;
            pri_d = IVS_PRI_CC1;
        end
        else if (rq_p2)
        begin
            vec_d = IVS_VEC_P2;
            pri_d = IVS_PRI_P2;
        end
        else if (rq_p1)
        begin
            vec_d = IVS_VEC_P1;
            pri_d = IVS_PRI_P1;
        end
        else
        begin
            req_d = 1'b0;
            vec_d = 16'h0000;
            pri_d = 5'h00;
        end
    end

    // ==========================================================
    // reset cause to reset vector
    // illegal fetch detection
    // all reset causes to top vector
    logic bad_fetch, rst_cause;
    assign bad_fetch = fetch_in && ((fetch_addr_in <= IVS_PERIPH_TOP)
        || (fetch_addr_in < code_bot_in) || (fetch_addr_in > code_top_in));
    assign rst_cause = bad_fetch | wdog_set | pin_reset_rise;

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            int_req_out <= 1'b0;
            vec_addr_out <= 16'h0000;
            vec_pri_out <= 5'h00;
            fetch_reset_out <= 1'b0;
        end
        else
        begin
            fetch_reset_out <= rst_cause;
            if (rst_cause | por_in)
            begin
                int_req_out <= 1'b1;
                vec_addr_out <= IVS_VEC_RESET;
                vec_pri_out <= IVS_PRI_RESET;
            end
            else
            begin
                int_req_out <= req_d;
                vec_addr_out <= vec_d;
                vec_pri_out <= pri_d;
            end
        end
    end

    // ==========================================================
    // erased reset vector means deepest sleep
    // sleep stops every clock and the crystal
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            deepest_sleep_mode_out <= 1'b0;
        else if (boot_check_in)
            deepest_sleep_mode_out <= (reset_vec_word_in == IVS_ERASED);
    end
    assign clocks_on_out = ~deepest_sleep_mode_out;

    // ==========================================================
    // checks
    property p_spare_zero;
        @(posedge clk_in) disable iff (!rstn_in)
        rd_in && (addr_in == IVS_OFF_EN2 || addr_in == IVS_OFF_FLG2)
        |=> rdata_out == 8'h00;
    endproperty
    a_spare_zero: assert property (p_spare_zero)
        else $error("spare register read not zero");

    property p_nmi_ignores_gie;
        @(posedge clk_in) disable iff (!rstn_in)
        !gie_in && rq_nmi && !rst_cause && !por_in
        |=> vec_addr_out == IVS_VEC_NMI && vec_pri_out == IVS_PRI_NMI;
    endproperty
    a_nmi_ignores_gie: assert property (p_nmi_ignores_gie)
        else $error("non-maskable request lost");

    property p_no_gie_no_mask;
        @(posedge clk_in) disable iff (!rstn_in)
        !gie_in && !rq_nmi && !rst_cause && !por_in |=> !int_req_out;
    endproperty
    a_no_gie_no_mask: assert property (p_no_gie_no_mask)
        else $error("maskable request passed without global enable");

    property p_erased_sleep;
        @(posedge clk_in) disable iff (!rstn_in)
        boot_check_in && reset_vec_word_in == IVS_ERASED
        |=> deepest_sleep_mode_out && !clocks_on_out;
    endproperty
    a_erased_sleep: assert property (p_erased_sleep)
        else $error("erased reset vector did not sleep");

    property p_low_fetch_reset;
        @(posedge clk_in) disable iff (!rstn_in)
        fetch_in && fetch_addr_in <= IVS_PERIPH_TOP
        |=> fetch_reset_out && vec_addr_out == IVS_VEC_RESET;
    endproperty
    a_low_fetch_reset: assert property (p_low_fetch_reset)
        else $error("fetch from register space without reset");

    property p_vec_range;
        @(posedge clk_in) disable iff (!rstn_in)
        int_req_out |-> vec_addr_out >= IVS_VEC_P1 && !vec_addr_out[0];
    endproperty
    a_vec_range: assert property (p_vec_range)
        else $error("vector outside used range");

    property p_puc_osc;
        @(posedge clk_in) disable iff (!rstn_in)
        puc_in |=> osc_f_q && en1_q == 8'h00;
    endproperty
    a_puc_osc: assert property (p_puc_osc)
        else $error("power-up clear effect missing");

    property p_wdog_mode;
        @(posedge clk_in) disable iff (!rstn_in)
        !wdog_interval_mode_in |=> vec_addr_out != IVS_VEC_WDOG;
    endproperty
    a_wdog_mode: assert property (p_wdog_mode)
        else $error("watchdog interrupt in reset mode");
endmodule

// ### dv/ivs_cpu_model.sv
// cpu side model: takes vectors, issues instruction fetches and boot checks
`timescale 1ns/10ps
module ivs_cpu_model
    import ivs_pkg::*;
(
    input wire logic clk_in,
    input wire logic int_req_in,
    input wire logic [15:0] vec_addr_in,
    output logic fetch_out,
    output logic [15:0] fetch_addr_out,
    output logic [15:0] reset_vec_word_out,
    output logic boot_check_out,
    output logic bad_vec_out
);
    initial
    begin
        fetch_out = 1'b0;
        fetch_addr_out = 16'h0000;
        reset_vec_word_out = 16'h0000;
        boot_check_out = 1'b0;
        bad_vec_out = 1'b0;
    end
    // ======================================================
    // vector fetch: words at or below the unused top are code
    always @(posedge clk_in)
    begin
        if (int_req_in === 1'b1 && vec_addr_in <= IVS_VEC_UNUSED_TOP)
            bad_vec_out <= 1'b1;
    end
    // ======================================================
    // bus requests
    task automatic do_fetch(input logic [15:0] a);
        @(posedge clk_in);
        fetch_out <= 1'b1;
        fetch_addr_out <= a;
        @(posedge clk_in);
        fetch_out <= 1'b0;
        // released address must not look like a held one
        fetch_addr_out <= ~a;
    endtask
    task automatic boot(input logic [15:0] w);
        @(posedge clk_in);
        reset_vec_word_out <= w;
        boot_check_out <= 1'b1;
        @(posedge clk_in);
        boot_check_out <= 1'b0;
    endtask
endmodule

// ### dv/ivs_core_tb_top.sv
// self-checking bench for the vector and special-function register block
`timescale 1ns/10ps
module ivs_core_tb_top
    import ivs_pkg::*;
;
    logic clk_in, rstn_in, por_in, puc_in, wr_in, rd_in, gie_in;
    logic [3:0] addr_in;
    logic [7:0] wdata_in, rdata_out, port1_pin_flags_in, en, fl;
    logic wdog_interval_mode_in, wdog_expire_in, flash_key_viol_flag_in;
    logic pin_reset_in, pin_nmi_in, osc_fault_in, flash_viol_flag_in;
    logic comparator_flag_in, cc_chan0_flag_in, cc_chan1_flag_in;
    logic timer_overflow_flag_in, fetch_in, boot_check_in, bad_vec;
    logic [1:0] port2_pin_flags_in;
    logic [15:0] fetch_addr_in, code_top_in, code_bot_in, reset_vec_word_in;
    logic int_req_out, fetch_reset_out, deepest_sleep_mode_out, clocks_on_out;
    logic [15:0] vec_addr_out, src, fa[7];
    logic [4:0] vec_pri_out;
    logic [21:0] e;
    logic [31:0] lfsr;
    int mismatches, num_checks;

    ivs_core #(.HAS_COMP(1'b1)) i_dut (.clk_in, .rstn_in, .por_in, .puc_in,
        .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .gie_in,
        .wdog_interval_mode_in, .wdog_expire_in, .flash_key_viol_flag_in,
        .pin_reset_in, .pin_nmi_in, .osc_fault_in, .flash_viol_flag_in,
        .comparator_flag_in, .cc_chan0_flag_in, .cc_chan1_flag_in,
        .timer_overflow_flag_in, .port2_pin_flags_in, .port1_pin_flags_in,
        .fetch_in, .fetch_addr_in, .code_top_in, .code_bot_in,
        .reset_vec_word_in, .boot_check_in, .int_req_out, .vec_addr_out,
        .vec_pri_out, .fetch_reset_out, .deepest_sleep_mode_out,
        .clocks_on_out);
    ivs_cpu_model i_cpu (.clk_in(clk_in), .int_req_in(int_req_out),
        .vec_addr_in(vec_addr_out), .fetch_out(fetch_in),
        .fetch_addr_out(fetch_addr_in), .reset_vec_word_out(reset_vec_word_in),
        .boot_check_out(boot_check_in), .bad_vec_out(bad_vec));

    // ======================================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // expected {request, priority, vector}; nmi group ignores gie
    function automatic logic [21:0] pick(input logic [7:0] n,
        input logic [7:0] f, input logic [15:0] s, input logic g);
        if ((s[6] & n[5]) | (f[1] & n[1]) | (f[4] & n[4]))
            return {1'b1, IVS_PRI_NMI, IVS_VEC_NMI};
        if (!g)
            return 22'h0;
        if (s[0])
            return {1'b1, IVS_PRI_COMP, IVS_VEC_COMP};
        if (f[0] & n[0] & s[7])
            return {1'b1, IVS_PRI_WDOG, IVS_VEC_WDOG};
        if (s[1])
            return {1'b1, IVS_PRI_CC0, IVS_VEC_CC0};
        if (s[2] | s[3])
            return {1'b1, IVS_PRI_CC1, IVS_VEC_CC1};
        if (|s[5:4])
            return {1'b1, IVS_PRI_P2, IVS_VEC_P2};
        if (|s[15:8])
            return {1'b1, IVS_PRI_P1, IVS_VEC_P1};
        return 22'h0;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] x);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk({24'h0, rdata_out}, {24'h0, x}, "register read");
    endtask
    // the reset pulse lasts one cycle, so look right after every edge
    task automatic saw_reset(input logic x);
        logic s;
        s = 1'b0;
        repeat (6)
        begin
            #1;
            if (fetch_reset_out === 1'b1)
            begin
                s = 1'b1;
                chk({15'h0, int_req_out, vec_addr_out},
                    {15'h0, 1'b1, IVS_VEC_RESET}, "reset vector");
            end
            @(posedge clk_in);
        end
        chk({31'h0, s}, {31'h0, x}, "fetch reset pulse");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial
    begin
        #(40 * 5000);
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        test_done();
    end

    // ======================================================
    // main sequence
    initial
    begin
        {rstn_in, por_in, puc_in, wr_in, rd_in, gie_in, wdog_expire_in} = '0;
        {wdog_interval_mode_in, flash_key_viol_flag_in, pin_reset_in} = '0;
        {pin_nmi_in, osc_fault_in, flash_viol_flag_in} = '0;
        {comparator_flag_in, cc_chan0_flag_in, cc_chan1_flag_in} = '0;
        {timer_overflow_flag_in, port2_pin_flags_in, port1_pin_flags_in} = '0;
        addr_in = 4'h0;
        wdata_in = 8'h00;
        code_top_in = 16'hffff;
        code_bot_in = 16'hf800;
        lfsr = 32'hc3c8;
        fa = '{16'h0000, 16'h01ff, 16'h0200, 16'hf7ff, 16'hf800, 16'hffde, 16'h1000};
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        rd_chk(IVS_OFF_EN1, IVS_EN1_RST);
        rd_chk(IVS_OFF_FLG1, 8'h06);
        rd_chk(4'h9, 8'h00);
        reg_wr(IVS_OFF_EN1, 8'hff);
        reg_wr(IVS_OFF_EN2, 8'hff);
        reg_wr(IVS_OFF_FLG2, 8'hff);
        reg_wr(IVS_OFF_FLG1, 8'hff);
        rd_chk(IVS_OFF_EN1, IVS_EN1_MASK);
        rd_chk(IVS_OFF_EN2, 8'h00);
        rd_chk(IVS_OFF_FLG2, 8'h00);
        rd_chk(IVS_OFF_FLG1, IVS_FLG1_MASK);
        reg_wr(IVS_OFF_FLG1, 8'h00);
        rd_chk(IVS_OFF_FLG1, 8'h00);
        @(posedge clk_in);
        puc_in <= 1'b1;
        @(posedge clk_in);
        puc_in <= 1'b0;
        rd_chk(IVS_OFF_EN1, 8'h00);
        rd_chk(IVS_OFF_FLG1, 8'h02);
        $display("register test done");
        reg_wr(IVS_OFF_FLG1, 8'h01);
        pin_reset_in <= 1'b1;
        saw_reset(1'b1);
        rd_chk(IVS_OFF_FLG1, 8'h08);
        pin_nmi_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        rd_chk(IVS_OFF_FLG1, 8'h18);
        // pins back to idle so no stale level meets a later reset
        {pin_reset_in, pin_nmi_in} <= 2'b00;
        reg_wr(IVS_OFF_FLG1, 8'h00);
        wdog_expire_in <= 1'b1;
        @(posedge clk_in);
        wdog_expire_in <= 1'b0;
        saw_reset(1'b1);
        rd_chk(IVS_OFF_FLG1, 8'h01);
        reg_wr(IVS_OFF_FLG1, 8'h00);
        flash_key_viol_flag_in <= 1'b1;
        @(posedge clk_in);
        flash_key_viol_flag_in <= 1'b0;
        rd_chk(IVS_OFF_FLG1, 8'h01);
        osc_fault_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        reg_wr(IVS_OFF_FLG1, 8'h08);
        rd_chk(IVS_OFF_FLG1, 8'h0a);
        osc_fault_in <= 1'b0;
        por_in <= 1'b1;
        @(posedge clk_in);
        por_in <= 1'b0;
        #1;
        chk({10'h0, int_req_out, vec_pri_out, vec_addr_out},
            {10'h0, 1'b1, IVS_PRI_RESET, IVS_VEC_RESET}, "power-on vector");
        rd_chk(IVS_OFF_FLG1, 8'h06);
        $display("flag test done");
        repeat (60)
        begin
            lfsr = lfsr_next(lfsr);
            en = lfsr[7:0];
            fl = {3'h0, lfsr[10] & lfsr[11], 2'h0, lfsr[9] & lfsr[12], lfsr[8]};
            reg_wr(IVS_OFF_EN1, en);
            reg_wr(IVS_OFF_FLG1, fl);
            lfsr = lfsr_next(lfsr);
            src = lfsr[15:0] & lfsr[31:16];
            @(posedge clk_in);
            {port1_pin_flags_in, wdog_interval_mode_in, flash_viol_flag_in} <= src[15:6];
            {port2_pin_flags_in, timer_overflow_flag_in} <= src[5:3];
            {cc_chan1_flag_in, cc_chan0_flag_in, comparator_flag_in} <= src[2:0];
            gie_in <= lfsr[16];
            @(posedge clk_in);
            #1;
            e = pick(en, fl, src, lfsr[16]);
            chk({31'h0, int_req_out}, {31'h0, e[21]}, "request");
            if (e[21])
                chk({11'h0, vec_pri_out, vec_addr_out}, {11'h0, e[20:0]}, "vector");
        end
        chk({31'h0, bad_vec}, 32'h0, "vector outside table");
        $display("priority test done");
        for (int i = 0; i < 7; i++)
        begin
            i_cpu.do_fetch(fa[i]);
            saw_reset(fa[i] <= IVS_PERIPH_TOP || fa[i] < code_bot_in);
        end
        $display("fetch test done");
        i_cpu.boot(16'hf800);
        repeat (2) @(posedge clk_in);
        #1;
        chk({30'h0, deepest_sleep_mode_out, clocks_on_out}, 32'h1, "awake");
        i_cpu.boot(IVS_ERASED);
        repeat (2) @(posedge clk_in);
        #1;
        chk({30'h0, deepest_sleep_mode_out, clocks_on_out}, 32'h2, "asleep");
        rstn_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk({30'h0, deepest_sleep_mode_out, clocks_on_out}, 32'h1, "rerun");
        $display("boot test done");
        test_done();
    end
endmodule
